//--- core/quadrature_encoder_io_status.sv
// Quadrature encoder I/O conditioning, event flags, position and velocity counters
`timescale 1ns/1ps
`default_nettype none
module quadrature_encoder_io_status (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [qenc_pkg::ADDR_W-1:0] addr_in,
  input wire logic [qenc_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [qenc_pkg::DATA_W-1:0] rdata_out,
  input wire logic phase_a_pin_in,
  input wire logic phase_b_pin_in,
  input wire logic index_pin_in,
  input wire logic homing_pin_in,
  output logic compare_output_pin_out,
  output logic irq_out
);
  import qenc_pkg::*;

  logic [DATA_W-1:0] io_control_r;
  logic [DATA_W-1:0] event_status_r;
  logic [DATA_W-1:0] control_r;
  logic [POS_W-1:0] position_counter_r;
  logic [DATA_W-1:0] position_holding_r;
  logic [DATA_W-1:0] velocity_counter_r;
  logic [POS_W-1:0] upper_compare_value_r;
  logic [POS_W-1:0] lower_compare_value_r;
  logic [POS_W-1:0] initialization_value_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic [PIN_N-1:0] levels;
  logic index_prev_r;
  logic home_prev_r;
  logic index_ev;
  logic home_ev;
  logic count_up;
  logic count_down;
  logic counting;
  logic homing_load;
  logic pos_ge;
  logic pos_le;
  logic pos_ov;
  logic vel_ov;
  logic [DATA_W-1:0] flag_set;
  homing_t homing_r;
  outf_t outf;

  // Write strobe aimed at one register
  function automatic logic wr_to(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off,
                                 input logic w);
    wr_to = w && (a == off);
  endfunction

  input_conditioner #(
    .N(PIN_N)
  ) u_cond (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .pins_in({homing_pin_in, index_pin_in, phase_b_pin_in, phase_a_pin_in}),
    .filter_en_in(io_control_r[IOC_FILTER_EN]),
    .divide_in(io_control_r[IOC_DIV_HI:IOC_DIV_LO]),
    .polarity_in(io_control_r[IOC_POL_HI:IOC_POL_LO]),
    .swap_in(io_control_r[IOC_SWAP]),
    .levels_out(levels)
  );

  quad_decoder u_dec (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .phase_a_in(levels[PIN_A]),
    .phase_b_in(levels[PIN_B]),
    .up_out(count_up),
    .down_out(count_down)
  );

  // Rising-edge event detection on the conditioned index and home levels
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      index_prev_r <= 1'b0;
      home_prev_r <= 1'b0;
    end else begin
      index_prev_r <= levels[PIN_INDEX];
      home_prev_r <= levels[PIN_HOME];
    end
  end
  assign index_ev = levels[PIN_INDEX] & ~index_prev_r;
  assign home_ev = levels[PIN_HOME] & ~home_prev_r;

  // I/O control register; low four bits are live levels on read
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      io_control_r <= RST_WORD;
    end else if (wr_to(addr_in, REG_IO_CONTROL, wr_in)) begin
      io_control_r <= {wdata_in[DATA_W-1:IOC_POL_LO], 4'h0};
    end
  end

  // Counter enable and initialization mode
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      control_r <= RST_WORD;
    end else if (wr_to(addr_in, REG_CONTROL, wr_in)) begin
      control_r <= wdata_in & CTL_MASK;
    end
  end

  // Homing sequencer: wait for one or two index events after home
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      homing_r <= HOMING_IDLE;
    end else if (!control_r[CTL_COUNT_EN]) begin
      homing_r <= HOMING_IDLE;
    end else begin
      case (homing_r)
        HOMING_IDLE: begin
          if (home_ev && control_r[CTL_MODE_HI:CTL_MODE_LO] == INIT_FIRST_INDEX) begin
            homing_r <= HOMING_WAIT_ONE;
          end else if (home_ev && control_r[CTL_MODE_HI:CTL_MODE_LO] == INIT_SECOND_INDEX) begin
            homing_r <= HOMING_WAIT_TWO;
          end
        end
        HOMING_WAIT_TWO: begin
          if (index_ev) begin
            homing_r <= HOMING_WAIT_ONE;
          end
        end
        HOMING_WAIT_ONE: begin
          if (index_ev) begin
            homing_r <= HOMING_IDLE;
          end
        end
        default: begin
          homing_r <= HOMING_IDLE;
        end
      endcase
    end
  end
  assign homing_load = control_r[CTL_COUNT_EN] && (homing_r == HOMING_WAIT_ONE)
                       && index_ev;

  // Counting only while enabled and exactly one of the up and down pulses is high
  assign counting = control_r[CTL_COUNT_EN] && (count_up ^ count_down);

  // Position counter: software word writes, homing reload, then counting
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      position_counter_r <= RST_POS;
    end else if (wr_to(addr_in, REG_POS_LOW, wr_in)) begin
      position_counter_r <= {position_holding_r, wdata_in};
    end else if (wr_to(addr_in, REG_POS_HIGH, wr_in)) begin
      position_counter_r <= {wdata_in, position_counter_r[DATA_W-1:0]};
    end else if (homing_load) begin
      position_counter_r <= initialization_value_r;
    end else if (counting) begin
      position_counter_r <= count_up ? position_counter_r + 32'h1 : position_counter_r - 32'h1;
    end
  end
  assign pos_ov = counting && !wr_to(addr_in, REG_POS_LOW, wr_in)
                  && !wr_to(addr_in, REG_POS_HIGH, wr_in) && !homing_load
                  && ((count_up && position_counter_r == POS_MAX)
                      || (count_down && position_counter_r == RST_POS));

  // Holding register: written directly or loaded by a low-word read
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      position_holding_r <= RST_WORD;
    end else if (wr_to(addr_in, REG_POS_HOLD, wr_in)) begin
      position_holding_r <= wdata_in;
    end else if (wr_to(addr_in, REG_POS_LOW, rd_in)) begin
      position_holding_r <= position_counter_r[POS_W-1:DATA_W];
    end
  end

  // Velocity counter follows the same count pulses
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      velocity_counter_r <= RST_WORD;
    end else if (wr_to(addr_in, REG_VELOCITY, wr_in)) begin
      velocity_counter_r <= wdata_in;
    end else if (counting) begin
      velocity_counter_r <= count_up ? velocity_counter_r + 16'h1 : velocity_counter_r - 16'h1;
    end
  end
  assign vel_ov = counting && !wr_to(addr_in, REG_VELOCITY, wr_in)
                  && ((count_up && velocity_counter_r == VEL_MAX)
                      || (count_down && velocity_counter_r == RST_WORD));

  // Compare, capture and initialization values
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      upper_compare_value_r <= RST_POS;
      lower_compare_value_r <= RST_POS;
    end else begin
      if (wr_to(addr_in, REG_UPPER_LOW, wr_in)) upper_compare_value_r[DATA_W-1:0] <= wdata_in;
      if (wr_to(addr_in, REG_UPPER_HIGH, wr_in)) upper_compare_value_r[POS_W-1:DATA_W] <= wdata_in;
      if (wr_to(addr_in, REG_LOWER_LOW, wr_in)) lower_compare_value_r[DATA_W-1:0] <= wdata_in;
      if (wr_to(addr_in, REG_LOWER_HIGH, wr_in)) lower_compare_value_r[POS_W-1:DATA_W] <= wdata_in;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      initialization_value_r <= RST_POS;
    end else if (home_ev && io_control_r[IOC_CAPTURE_EN]) begin
      initialization_value_r <= position_counter_r;
    end else if (wr_to(addr_in, REG_INIT_LOW, wr_in)) begin
      initialization_value_r[DATA_W-1:0] <= wdata_in;
    end else if (wr_to(addr_in, REG_INIT_HIGH, wr_in)) begin
      initialization_value_r[POS_W-1:DATA_W] <= wdata_in;
    end
  end

  assign pos_ge = $signed(position_counter_r) >= $signed(upper_compare_value_r);
  assign pos_le = $signed(position_counter_r) <= $signed(lower_compare_value_r);

  // Hardware set terms for every flag
  always_comb begin
    flag_set = RST_WORD;
    flag_set[ST_GE_FLAG] = pos_ge;
    flag_set[ST_LE_FLAG] = pos_le;
    flag_set[ST_POSOV_FLAG] = pos_ov;
    flag_set[ST_HOMING_DONE_FLAG] = homing_load;
    flag_set[ST_VELOV_FLAG] = vel_ov;
    flag_set[ST_HOME_FLAG] = home_ev;
    flag_set[ST_INDEX_FLAG] = index_ev;
  end

  // Status: write 1 clears a flag, enables are plain read/write, set wins
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      event_status_r <= RST_WORD;
    end else if (wr_to(addr_in, REG_EVENT_STATUS, wr_in)) begin
      event_status_r <= (wdata_in & ST_ENABLE_MASK)
                        | (event_status_r & ST_FLAG_MASK & ~wdata_in)
                        | flag_set;
    end else begin
      event_status_r <= event_status_r | flag_set;
    end
  end

  // Interrupt request from enabled flags only
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(event_status_r & ST_FLAG_MASK & (event_status_r << 1));
    end
  end

  // Compare output pin per output function
  assign outf = outf_t'(io_control_r[IOC_OUTF_HI:IOC_OUTF_LO]);
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      compare_output_pin_out <= 1'b0;
    end else begin
      case (outf)
        OUTF_GE: compare_output_pin_out <= pos_ge;
        OUTF_LE: compare_output_pin_out <= pos_le;
        OUTF_BOTH: compare_output_pin_out <= pos_ge | pos_le;
        default: compare_output_pin_out <= 1'b0;
      endcase
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    case (addr_in)
      REG_IO_CONTROL: rdata_nxt = {io_control_r[DATA_W-1:IOC_POL_LO], levels};
      REG_EVENT_STATUS: rdata_nxt = event_status_r;
      REG_POS_HIGH: rdata_nxt = position_counter_r[POS_W-1:DATA_W];
      REG_POS_LOW: rdata_nxt = position_counter_r[DATA_W-1:0];
      REG_POS_HOLD: rdata_nxt = position_holding_r;
      REG_VELOCITY: rdata_nxt = velocity_counter_r;
      REG_CONTROL: rdata_nxt = control_r;
      REG_UPPER_LOW: rdata_nxt = upper_compare_value_r[DATA_W-1:0];
      REG_UPPER_HIGH: rdata_nxt = upper_compare_value_r[POS_W-1:DATA_W];
      REG_LOWER_LOW: rdata_nxt = lower_compare_value_r[DATA_W-1:0];
      REG_LOWER_HIGH: rdata_nxt = lower_compare_value_r[POS_W-1:DATA_W];
      REG_INIT_LOW: rdata_nxt = initialization_value_r[DATA_W-1:0];
      REG_INIT_HIGH: rdata_nxt = initialization_value_r[POS_W-1:DATA_W];
      default: rdata_nxt = RST_WORD;
    endcase
  end

  // Read data stand for exactly the cycle after the strobe
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      rdata_out <= RST_WORD;
    end else begin
      rdata_out <= rd_in ? rdata_nxt : RST_WORD;
    end
  end
endmodule
`default_nettype wire

//--- shared/qenc_pkg.sv
// Register map, field layout and encodings of the quadrature encoder unit
package qenc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int POS_W = 32;
  localparam int PIN_N = 4;

  // Register word indices
  localparam logic [ADDR_W-1:0] REG_IO_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_EVENT_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] REG_POS_HIGH = 4'h2;
  localparam logic [ADDR_W-1:0] REG_POS_LOW = 4'h3;
  localparam logic [ADDR_W-1:0] REG_POS_HOLD = 4'h4;
  localparam logic [ADDR_W-1:0] REG_VELOCITY = 4'h5;
  localparam logic [ADDR_W-1:0] REG_CONTROL = 4'h6;
  localparam logic [ADDR_W-1:0] REG_UPPER_LOW = 4'h7;
  localparam logic [ADDR_W-1:0] REG_UPPER_HIGH = 4'h8;
  localparam logic [ADDR_W-1:0] REG_LOWER_LOW = 4'h9;
  localparam logic [ADDR_W-1:0] REG_LOWER_HIGH = 4'ha;
  localparam logic [ADDR_W-1:0] REG_INIT_LOW = 4'hb;
  localparam logic [ADDR_W-1:0] REG_INIT_HIGH = 4'hc;

  // I/O control fields
  localparam int IOC_CAPTURE_EN = 15;
  localparam int IOC_FILTER_EN = 14;
  localparam int IOC_DIV_HI = 13;
  localparam int IOC_DIV_LO = 11;
  localparam int IOC_OUTF_HI = 10;
  localparam int IOC_OUTF_LO = 9;
  localparam int IOC_SWAP = 8;
  localparam int IOC_POL_HI = 7;
  localparam int IOC_POL_LO = 4;
  localparam int IOC_LEVEL_HI = 3;
  // Pin vector order: 3 home, 2 index, 1 phase B, 0 phase A
  localparam int PIN_HOME = 3;
  localparam int PIN_INDEX = 2;
  localparam int PIN_B = 1;
  localparam int PIN_A = 0;

  // Event status fields: flags on odd bits, their enables one bit below
  localparam int ST_GE_FLAG = 13;
  localparam int ST_LE_FLAG = 11;
  localparam int ST_POSOV_FLAG = 9;
  localparam int ST_HOMING_DONE_FLAG = 7;
  localparam int ST_VELOV_FLAG = 5;
  localparam int ST_HOME_FLAG = 3;
  localparam int ST_INDEX_FLAG = 1;
  localparam logic [DATA_W-1:0] ST_FLAG_MASK = 16'h2aaa;
  localparam logic [DATA_W-1:0] ST_ENABLE_MASK = 16'h1555;

  // Control fields
  localparam int CTL_COUNT_EN = 15;
  localparam int CTL_MODE_HI = 12;
  localparam int CTL_MODE_LO = 10;
  localparam logic [DATA_W-1:0] CTL_MASK = 16'h9c00;

  localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
  localparam logic [POS_W-1:0] RST_POS = 32'h0000_0000;
  localparam logic [POS_W-1:0] POS_MAX = 32'hffff_ffff;
  localparam logic [DATA_W-1:0] VEL_MAX = 16'hffff;

  // Filter: a changed input must be seen on one more divided tick than this
  localparam logic [1:0] FILT_STABLE = 2'h2;

  typedef enum logic [1:0] {
    OUTF_OFF = 2'b00,
    OUTF_GE = 2'b01,
    OUTF_LE = 2'b10,
    OUTF_BOTH = 2'b11
  } outf_t;

  localparam logic [2:0] INIT_FIRST_INDEX = 3'b011;
  localparam logic [2:0] INIT_SECOND_INDEX = 3'b100;

  typedef enum logic [1:0] {
    HOMING_IDLE = 2'b00,
    HOMING_WAIT_ONE = 2'b01,
    HOMING_WAIT_TWO = 2'b10
  } homing_t;
endpackage

//--- core/input_conditioner.sv
// Pin synchroniser, digital noise filter, polarity inversion and phase swap
`timescale 1ns/1ps
`default_nettype none
module input_conditioner #(
  parameter int N = qenc_pkg::PIN_N
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [N-1:0] pins_in,
  input wire logic filter_en_in,
  input wire logic [2:0] divide_in,
  input wire logic [N-1:0] polarity_in,
  input wire logic swap_in,
  output logic [N-1:0] levels_out
);
  import qenc_pkg::*;

  logic [N-1:0] sync1_r;
  logic [N-1:0] sync2_r;
  logic [N-1:0] filt_r;
  logic [7:0] div_cnt_r;
  logic tick;
  logic [N-1:0] pol;

  // Two-stage synchroniser on the raw pins
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pins_in;
      sync2_r <= sync1_r;
    end
  end

  // Filter clock divider, 1:1 up to 1:128
  assign tick = (div_cnt_r == ((8'h01 << divide_in) - 8'h01));
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      div_cnt_r <= 8'h00;
    end else if (tick) begin
      div_cnt_r <= 8'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end

  // Per-pin filter: new level accepted after being stable over several ticks
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_filt
      logic [1:0] stable_r;
      always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
          stable_r <= 2'h0;
          filt_r[g] <= 1'b0;
        end else if (!filter_en_in) begin
          stable_r <= 2'h0;
          filt_r[g] <= sync2_r[g];
        end else if (sync2_r[g] == filt_r[g]) begin
          stable_r <= 2'h0;
        end else if (tick) begin
          if (stable_r == FILT_STABLE) begin
            filt_r[g] <= sync2_r[g];
            stable_r <= 2'h0;
          end else begin
            stable_r <= stable_r + 2'h1;
          end
        end
      end
    end
  endgenerate

  // Polarity first, then the phase swap
  assign pol = filt_r ^ polarity_in;
  always_comb begin
    levels_out = pol;
    if (swap_in) begin
      levels_out[PIN_A] = pol[PIN_B];
      levels_out[PIN_B] = pol[PIN_A];
    end
  end
endmodule
`default_nettype wire

//--- core/quad_decoder.sv
// x4 quadrature decoder giving one-cycle up and down count pulses
`timescale 1ns/1ps
`default_nettype none
module quad_decoder (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic phase_a_in,
  input wire logic phase_b_in,
  output logic up_out,
  output logic down_out
);
  logic a_r;
  logic b_r;
  logic a_chg;
  logic b_chg;

  assign a_chg = phase_a_in ^ a_r;
  assign b_chg = phase_b_in ^ b_r;

  // Every edge of either phase counts; a double change is ignored
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      a_r <= 1'b0;
      b_r <= 1'b0;
      up_out <= 1'b0;
      down_out <= 1'b0;
    end else begin
      a_r <= phase_a_in;
      b_r <= phase_b_in;
      up_out <= (a_chg ^ b_chg) & ((phase_a_in ^ b_r) == 1'b1) & a_chg
              | (a_chg ^ b_chg) & b_chg & ~(phase_b_in ^ a_r);
      down_out <= (a_chg ^ b_chg) & a_chg & ~(phase_a_in ^ b_r)
                | (a_chg ^ b_chg) & b_chg & (phase_b_in ^ a_r);
    end
  end
endmodule
`default_nettype wire

//--- tb/qenc_monitor.sv
// Port-level checks of the quadrature encoder unit
`timescale 1ns/1ps
`default_nettype none
module qenc_monitor (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [qenc_pkg::ADDR_W-1:0] addr_in,
  input wire logic [qenc_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [qenc_pkg::DATA_W-1:0] rdata_out,
  input wire logic compare_output_pin_out,
  input wire logic irq_out
);
  import qenc_pkg::*;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  // Write, idle slot, then read of the same word
  sequence wr_s(a);
    wr_in && addr_in == a;
  endsequence
  sequence wr_rd_s(a);
    wr_s(a) ##1 !wr_in ##1 rd_in && addr_in == a;
  endsequence
  // Read data only in the slot after a read, zero elsewhere
  rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
    else $error("read data outside read slot");
  unmapped_read_a: assert property ($past(rd_in) && $past(addr_in) > REG_INIT_HIGH
    |-> rdata_out == 16'h0000) else $error("unmapped word read nonzero");
  reset_quiet_a: assert property ($rose(nrst_in)
    |-> !irq_out && !compare_output_pin_out) else $error("output active after reset");
  // Writable fields read back as written
  ioc_readback_a: assert property (wr_rd_s(REG_IO_CONTROL)
    |=> rdata_out[15:4] == $past(wdata_in[15:4], 3)) else $error("io control readback");
  enables_readback_a: assert property (wr_rd_s(REG_EVENT_STATUS)
    |=> (rdata_out & ST_ENABLE_MASK) == ($past(wdata_in, 3) & ST_ENABLE_MASK))
    else $error("enable bits readback");
  // Request and compare pin follow their enables
  irq_mask_a: assert property (wr_in && addr_in == REG_EVENT_STATUS
    && (wdata_in & ST_ENABLE_MASK) == 16'h0000 ##1 !wr_in |=> !irq_out)
    else $error("request with all enables clear");
  cmp_off_a: assert property (wr_in && addr_in == REG_IO_CONTROL
    && wdata_in[IOC_OUTF_HI:IOC_OUTF_LO] == OUTF_OFF ##1 !wr_in |=> !compare_output_pin_out)
    else $error("compare pin high while off");
  irq_match_a: assert property ($past(rd_in) && $past(addr_in) == REG_EVENT_STATUS
    |-> irq_out == |(rdata_out & (rdata_out >> 1) & ST_ENABLE_MASK))
    else $error("request differs from enabled flags");
endmodule
bind quadrature_encoder_io_status qenc_monitor qenc_monitor_i (.mclk_in(mclk_in),
  .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .compare_output_pin_out(compare_output_pin_out), .irq_out(irq_out));
`default_nettype wire

//--- tb/encoder_model.sv
// Incremental encoder model with index and home pins
`timescale 1ns/1ps
`default_nettype none
module encoder_model (
  input wire logic clk_in,
  output logic phase_a_out,
  output logic phase_b_out,
  output logic index_out,
  output logic home_out
);
  logic [3:0] pins_r;
  logic [1:0] st_r;
  // Pin vector: home, index, phase B, phase A
  assign {home_out, index_out, phase_b_out, phase_a_out} = pins_r;
  initial begin
    pins_r = 4'h0;
    st_r = 2'h0;
  end
  // Set all pins at once, keeping the gray state in step
  task automatic set_pins(input logic [3:0] v);
    @(posedge clk_in);
    pins_r <= v;
    st_r = {v[1], v[1] ^ v[0]};
  endtask
  // Walk the gray cycle, A leading B when moving up; gap sets the speed
  task automatic move(input bit up, input int n, input int gap);
    repeat (n) begin
      st_r = up ? st_r + 2'h1 : st_r - 2'h1;
      @(posedge clk_in);
      pins_r[0] <= st_r[0] ^ st_r[1];
      pins_r[1] <= st_r[1];
      repeat (gap) @(posedge clk_in);
    end
  endtask
  // Raise one pin for six cycles
  task automatic pulse(input int p);
    @(posedge clk_in);
    pins_r[p] <= 1'b1;
    repeat (6) @(posedge clk_in);
    pins_r[p] <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the quadrature encoder unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import qenc_pkg::*;
  logic mclk_in;
  logic nrst_in;
  logic [ADDR_W-1:0] addr_in;
  logic [DATA_W-1:0] wdata_in;
  logic wr_in;
  logic rd_in;
  logic [DATA_W-1:0] rdata_out;
  logic pa, pb, pi, ph, cmp_pin, irq;
  int errors = 0;
  int checks = 0;
  int n, f, m, k;
  int qt [5] = '{20, 10, 0, -3, -9};
  logic [15:0] v;
  logic [31:0] p, ini;
  // 20 MHz clock
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  quadrature_encoder_io_status quadrature_encoder_io_status_i (.mclk_in(mclk_in),
    .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .phase_a_pin_in(pa), .phase_b_pin_in(pb), .index_pin_in(pi),
    .homing_pin_in(ph), .compare_output_pin_out(cmp_pin), .irq_out(irq));
  encoder_model encoder_model_i (.clk_in(mclk_in), .phase_a_out(pa), .phase_b_out(pb),
    .index_out(pi), .home_out(ph));
  // Bus cycles and comparisons
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk($sformatf("register %0h", a), {16'h0, e}, {16'h0, d});
  endtask
  task automatic wpos(input logic [31:0] q);
    wr(REG_POS_HOLD, q[31:16]);
    wr(REG_POS_LOW, q[15:0]);
  endtask
  task automatic cpos(input logic [31:0] e);
    logic [15:0] lo, hi;
    rd(REG_POS_LOW, lo);
    rd(REG_POS_HOLD, hi);
    chk("position", e, {hi, lo});
  endtask
  task automatic results;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Expected levels and compare result
  function automatic logic [3:0] lev(logic [3:0] pin, logic [3:0] pol, logic sw);
    lev = pin ^ pol;
    if (sw) lev[1:0] = {lev[0], lev[1]};
  endfunction
  function automatic logic cmpx(logic [1:0] fn, logic signed [31:0] q);
    cmpx = (fn[0] && q >= 10) || (fn[1] && q <= -3);
  endfunction
  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk_in);
    errors++;
    results;
  end
  // Test sequence
  initial begin
    nrst_in = 1'b0;
    addr_in = 4'h0;
    wdata_in = 16'h0000;
    wr_in = 1'b0;
    rd_in = 1'b0;
    n = $urandom(32'he35b0963);
    repeat (5) @(posedge mclk_in);
    nrst_in <= 1'b1;
    // Position and both compare values sit at zero, so both compare flags read set
    for (k = 0; k < 16; k++) begin
      v = (k == int'(REG_EVENT_STATUS)) ? ((16'h0001 << ST_GE_FLAG) | (16'h0001 << ST_LE_FLAG))
                                        : 16'h0000;
      rc(k[3:0], v);
    end
    for (k = 0; k < 8; k++) begin
      v = 16'($urandom);
      v[15:14] = 2'h0;
      n = $urandom;
      encoder_model_i.set_pins(n[3:0]);
      wr(REG_IO_CONTROL, v);
      repeat (8) @(posedge mclk_in);
      rc(REG_IO_CONTROL, {v[15:4], lev(n[3:0], v[7:4], v[8])});
    end
    encoder_model_i.set_pins(4'h0);
    repeat (6) @(posedge mclk_in);
    wr(REG_IO_CONTROL, 16'h7800);
    rc(REG_IO_CONTROL, 16'h7800);
    encoder_model_i.set_pins(4'h8);
    repeat (8) @(posedge mclk_in);
    rc(REG_IO_CONTROL, 16'h7800);
    repeat (400) @(posedge mclk_in);
    rc(REG_IO_CONTROL, 16'h7808);
    wr(REG_IO_CONTROL, 16'h0000);
    encoder_model_i.set_pins(4'h0);
    wr(REG_UPPER_LOW, 16'hffff);
    wr(REG_UPPER_HIGH, 16'h7fff);
    wr(REG_LOWER_HIGH, 16'h8000);
    encoder_model_i.move(1'b1, 3, 3);
    repeat (10) @(posedge mclk_in);
    cpos(32'h0);
    wr(REG_CONTROL, 16'h8000);
    wr(REG_EVENT_STATUS, ST_FLAG_MASK);
    n = $urandom_range(20, 1);
    encoder_model_i.move(1'b1, n, 3);
    repeat (10) @(posedge mclk_in);
    cpos(n);
    encoder_model_i.move(1'b0, 2 * n, 3);
    repeat (10) @(posedge mclk_in);
    cpos(-n);
    rc(REG_VELOCITY, 16'(-n));
    rc(REG_EVENT_STATUS, 16'h0220);
    p = $urandom;
    wpos(p);
    cpos(p);
    rc(REG_POS_HIGH, p[31:16]);
    wr(REG_UPPER_LOW, 16'h000a);
    wr(REG_UPPER_HIGH, 16'h0000);
    wr(REG_LOWER_LOW, 16'hfffd);
    wr(REG_LOWER_HIGH, 16'hffff);
    for (k = 0; k < 5; k++) begin
      wpos(qt[k]);
      wr(REG_EVENT_STATUS, ST_FLAG_MASK);
      rc(REG_EVENT_STATUS, {2'h0, cmpx(2'h1, qt[k]), 1'b0, cmpx(2'h2, qt[k]), 11'h0});
      for (f = 0; f < 4; f++) begin
        wr(REG_IO_CONTROL, 16'(f << 9));
        repeat (4) @(posedge mclk_in);
        chk("compare pin", 32'(cmpx(f[1:0], qt[k])), 32'(cmp_pin));
      end
    end
    // Home flag raises the request, masked flag stays set, index flag
    wpos(32'h0);
    wr(REG_EVENT_STATUS, ST_FLAG_MASK);
    wr(REG_EVENT_STATUS, 16'h0004);
    encoder_model_i.pulse(3);
    chk("irq", 32'h1, 32'(irq));
    rc(REG_EVENT_STATUS, 16'h000c);
    wr(REG_EVENT_STATUS, 16'h0000);
    repeat (3) @(posedge mclk_in);
    chk("irq", 32'h0, 32'(irq));
    encoder_model_i.pulse(2);
    rc(REG_EVENT_STATUS, 16'h000a);
    wr(REG_EVENT_STATUS, 16'h000a);
    rc(REG_EVENT_STATUS, 16'h0000);
    // Homing reload on first or second index after home
    ini = $urandom_range(9, 1);
    wr(REG_INIT_LOW, ini[15:0]);
    wr(REG_INIT_HIGH, ini[31:16]);
    for (m = 3; m < 5; m++) begin
      wpos(32'h0);
      wr(REG_EVENT_STATUS, ST_FLAG_MASK);
      wr(REG_CONTROL, {1'b1, 2'h0, m[2:0], 10'h0});
      encoder_model_i.pulse(3);
      for (k = 3; k <= m; k++) begin
        cpos(32'h0);
        encoder_model_i.pulse(2);
      end
      cpos(ini);
      rc(REG_EVENT_STATUS, 16'h008a);
    end
    // Capture on home only while enabled
    wr(REG_CONTROL, 16'h8000);
    wpos(p);
    wr(REG_IO_CONTROL, 16'h8000);
    encoder_model_i.pulse(3);
    rc(REG_INIT_LOW, p[15:0]);
    rc(REG_INIT_HIGH, p[31:16]);
    wr(REG_IO_CONTROL, 16'h0000);
    wpos(~p);
    encoder_model_i.pulse(3);
    rc(REG_INIT_LOW, p[15:0]);
    results;
  end
endmodule
`default_nettype wire
